// [design/ptc_time_clock.v]
`timescale 1ns/1ns
`default_nettype none
`include "ptc_regs.vh"

module ptc_time_clock
#(
    parameter NPORTS = 3
)
(
    // Clock and reset
    input wire ref_clk_in,
    input wire rst_in,
    // Register port
    input wire [11:0] reg_addr_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [31:0] reg_wdata_in,
    output reg [31:0] reg_rdata_out,
    // Port packet detectors, index 0 = port 0, 1 = port 1, 2 = port 2
    input wire [NPORTS-1:0] tx_sync_seen_in,
    input wire [NPORTS-1:0] tx_delay_req_seen_in,
    input wire [NPORTS*32-1:0] tx_source_identity_low_in,
    // Capture pins, asynchronous
    input wire pin_a_in,
    input wire pin_b_in,
    // Time outputs
    output wire [63:0] time_now_out,
    output reg time_match_out
);

    // ****************************************
    // Register decode
    // ****************************************
    // Exact address match; unmapped and read-only writes fall through unused
    wire wr_time_upper = reg_wr_in && (reg_addr_in == `PTC_OFS_TIME_UPPER);
    wire wr_time_lower = reg_wr_in && (reg_addr_in == `PTC_OFS_TIME_LOWER);
    wire wr_rate = reg_wr_in && (reg_addr_in == `PTC_OFS_RATE_TRIM);
    wire wr_match_upper = reg_wr_in && (reg_addr_in == `PTC_OFS_MATCH_UPPER);
    wire wr_match_lower = reg_wr_in && (reg_addr_in == `PTC_OFS_MATCH_LOWER);
    wire wr_config = reg_wr_in && (reg_addr_in == `PTC_OFS_CONFIG);
    wire wr_command = reg_wr_in && (reg_addr_in == `PTC_OFS_COMMAND);

    reg [31:0] rate_trim_increment;
    reg [31:0] config_word;
    reg [31:0] time_upper_word;
    reg [31:0] time_lower_word;
    reg [31:0] match_upper_word;
    reg [31:0] match_lower_word;
    reg [1:0] time_half_seen;
    reg [1:0] match_half_seen;
    reg [63:0] match_value;
    reg [63:0] time_count;
    reg [31:0] freq_accum;

    // ****************************************
    // Configuration and rate trim
    // ****************************************
    always @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            rate_trim_increment <= `PTC_RST_WORD;
            config_word <= `PTC_RST_WORD;
        end
        else
        begin
            if (wr_rate)
            begin
                rate_trim_increment <= reg_wdata_in;
            end
            if (wr_config)
            begin
                // Only the master select bits are used; the rest read back as written
                config_word <= reg_wdata_in;
            end
        end
    end

    // ****************************************
    // Split-word writes of time and match
    // ****************************************
    // Either order is fine; the pair commits on the second half
    wire time_commit = (time_half_seen[1] | wr_time_upper)
        && (time_half_seen[0] | wr_time_lower);
    wire match_commit = (match_half_seen[1] | wr_match_upper)
        && (match_half_seen[0] | wr_match_lower);

    always @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            match_upper_word <= `PTC_RST_WORD;
            match_lower_word <= `PTC_RST_WORD;
            match_half_seen <= 2'b00;
            time_half_seen <= 2'b00;
            match_value <= 64'h0000_0000_0000_0000;
        end
        else
        begin
            if (wr_match_upper)
            begin
                match_upper_word <= reg_wdata_in;
            end
            if (wr_match_lower)
            begin
                match_lower_word <= reg_wdata_in;
            end
            if (match_commit)
            begin
                match_half_seen <= 2'b00;
                match_value <= {wr_match_upper ? reg_wdata_in : match_upper_word,
                    wr_match_lower ? reg_wdata_in : match_lower_word};
            end
            else
            begin
                match_half_seen <= match_half_seen | {wr_match_upper, wr_match_lower};
            end
            if (time_commit)
            begin
                time_half_seen <= 2'b00;
            end
            else
            begin
                time_half_seen <= time_half_seen | {wr_time_upper, wr_time_lower};
            end
        end
    end

    // Staging words hold the pending write until the pair completes
    reg [31:0] time_stage_upper;
    reg [31:0] time_stage_lower;
    always @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            time_stage_upper <= `PTC_RST_WORD;
            time_stage_lower <= `PTC_RST_WORD;
        end
        else
        begin
            if (wr_time_upper)
            begin
                time_stage_upper <= reg_wdata_in;
            end
            if (wr_time_lower)
            begin
                time_stage_lower <= reg_wdata_in;
            end
        end
    end
    // Second half comes straight off the bus so the load is not a cycle late
    wire [63:0] time_load_value = {wr_time_upper ? reg_wdata_in : time_stage_upper,
        wr_time_lower ? reg_wdata_in : time_stage_lower};

    // ****************************************
    // Time counter with fractional rate trim
    // ****************************************
    // Increment of all ones steps nearly every cycle; zero stops the clock
    wire [32:0] accum_sum = {1'b0, freq_accum} + {1'b0, rate_trim_increment};
    wire accum_carry = accum_sum[32];

    always @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            freq_accum <= `PTC_RST_WORD;
            time_count <= 64'h0000_0000_0000_0000;
        end
        else
        begin
            freq_accum <= accum_sum[31:0];
            if (time_commit)
            begin
                // A software load wins over a step in the same cycle
                time_count <= time_load_value;
            end
            else if (accum_carry)
            begin
                time_count <= time_count + 64'h0000_0000_0000_0001;
            end
        end
    end
    assign time_now_out = time_count;

    // ****************************************
    // Match compare
    // ****************************************
    always @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            time_match_out <= 1'b0;
        end
        else
        begin
            // Registered, so the flag trails equality by one cycle
            time_match_out <= (time_count == match_value);
        end
    end

    // ****************************************
    // Snapshot for time reads
    // ****************************************
    always @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            time_upper_word <= `PTC_RST_WORD;
            time_lower_word <= `PTC_RST_WORD;
        end
        else if (wr_command && reg_wdata_in[`PTC_CMD_FREEZE])
        begin
            // Both halves frozen together so a split read never tears
            time_upper_word <= time_count[63:32];
            time_lower_word <= time_count[31:0];
        end
    end

    // ****************************************
    // Capture pin synchronisers and edges
    // ****************************************
    // Two flops against metastability; capture lags the pin by three edges
    reg [1:0] pin_a_sync;
    reg [1:0] pin_b_sync;
    reg pin_a_last;
    reg pin_b_last;
    always @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            pin_a_sync <= 2'b00;
            pin_b_sync <= 2'b00;
            pin_a_last <= 1'b0;
            pin_b_last <= 1'b0;
        end
        else
        begin
            pin_a_sync <= {pin_a_sync[0], pin_a_in};
            pin_b_sync <= {pin_b_sync[0], pin_b_in};
            pin_a_last <= pin_a_sync[1];
            pin_b_last <= pin_b_sync[1];
        end
    end
    // Activation is the rising edge after synchronisation
    wire pin_a_fire = pin_a_sync[1] && !pin_a_last;
    wire pin_b_fire = pin_b_sync[1] && !pin_b_last;

    wire [63:0] pin_a_stamp;
    wire [63:0] pin_b_stamp;
    ptc_cap_word #(.WIDTH(64)) u_pin_a
    (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .load_in(pin_a_fire),
        .data_in(time_count),
        .value_out(pin_a_stamp)
    );
    ptc_cap_word #(.WIDTH(64)) u_pin_b
    (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .load_in(pin_b_fire),
        .data_in(time_count),
        .value_out(pin_b_stamp)
    );

    // ****************************************
    // Per-port transmit source identity capture
    // ****************************************
    // Detector pulses come from this clock, so no synchroniser is needed
    wire [NPORTS*32-1:0] tx_source_identity_low;
    wire [2:0] port_master_select = {config_word[`PTC_CFG_MASTER_P2],
        config_word[`PTC_CFG_MASTER_P1], config_word[`PTC_CFG_MASTER_P0]};
    genvar gp;
    generate
        for (gp = 0; gp < NPORTS; gp = gp + 1)
        begin : g_port
            // Master stamps its own Sync, slave its own Delay_Req
            wire take = port_master_select[gp] ? tx_sync_seen_in[gp]
                : tx_delay_req_seen_in[gp];
            ptc_cap_word #(.WIDTH(32)) u_src
            (
                .ref_clk_in(ref_clk_in),
                .rst_in(rst_in),
                .load_in(take),
                .data_in(tx_source_identity_low_in[gp*32 +: 32]),
                .value_out(tx_source_identity_low[gp*32 +: 32])
            );
        end
    endgenerate

    // ****************************************
    // Read mux
    // ****************************************
    always @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            reg_rdata_out <= `PTC_RST_WORD;
        end
        else if (reg_rd_in)
        begin
            // Data holds until the next read; unmapped offsets read as zero
            case (reg_addr_in)
                `PTC_OFS_P1_SRC_LOW: reg_rdata_out <= tx_source_identity_low[63:32];
                `PTC_OFS_P2_SRC_LOW: reg_rdata_out <= tx_source_identity_low[95:64];
                `PTC_OFS_P0_SRC_LOW: reg_rdata_out <= tx_source_identity_low[31:0];
                `PTC_OFS_PIN_A_UPPER: reg_rdata_out <= pin_a_stamp[63:32];
                `PTC_OFS_PIN_A_LOWER: reg_rdata_out <= pin_a_stamp[31:0];
                `PTC_OFS_PIN_B_UPPER: reg_rdata_out <= pin_b_stamp[63:32];
                `PTC_OFS_PIN_B_LOWER: reg_rdata_out <= pin_b_stamp[31:0];
                `PTC_OFS_TIME_UPPER: reg_rdata_out <= time_upper_word;
                `PTC_OFS_TIME_LOWER: reg_rdata_out <= time_lower_word;
                `PTC_OFS_RATE_TRIM: reg_rdata_out <= rate_trim_increment;
                `PTC_OFS_MATCH_UPPER: reg_rdata_out <= match_upper_word;
                `PTC_OFS_MATCH_LOWER: reg_rdata_out <= match_lower_word;
                `PTC_OFS_CONFIG: reg_rdata_out <= config_word;
                default: reg_rdata_out <= `PTC_RST_WORD;
            endcase
        end
    end

endmodule // ptc_time_clock

`default_nettype wire

// [design/ptc_regs.vh]
`ifndef PTC_REGS_VH
`define PTC_REGS_VH

// Register offsets (byte addresses)
`define PTC_OFS_P1_SRC_LOW 12'h011C
`define PTC_OFS_P2_SRC_LOW 12'h013C
`define PTC_OFS_P0_SRC_LOW 12'h015C
`define PTC_OFS_PIN_A_UPPER 12'h0160
`define PTC_OFS_PIN_A_LOWER 12'h0164
`define PTC_OFS_PIN_B_UPPER 12'h0168
`define PTC_OFS_PIN_B_LOWER 12'h016C
`define PTC_OFS_TIME_UPPER 12'h0170
`define PTC_OFS_TIME_LOWER 12'h0174
`define PTC_OFS_RATE_TRIM 12'h0178
`define PTC_OFS_MATCH_UPPER 12'h017C
`define PTC_OFS_MATCH_LOWER 12'h0180
`define PTC_OFS_CONFIG 12'h0194
`define PTC_OFS_COMMAND 12'h0198

// Field positions
`define PTC_CFG_MASTER_P2 31
`define PTC_CFG_MASTER_P1 30
`define PTC_CFG_MASTER_P0 29
`define PTC_CMD_FREEZE 0

// Reset values
`define PTC_RST_WORD 32'h0000_0000

`endif

// [design/ptc_cap_word.v]
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Capture word with registered read-out
// ****************************************
module ptc_cap_word
#(
    parameter WIDTH = 32
)
(
    // Clock and reset
    input wire ref_clk_in,
    input wire rst_in,
    // Load side
    input wire load_in,
    input wire [WIDTH-1:0] data_in,
    // Read side
    output reg [WIDTH-1:0] value_out
);

    always @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            value_out <= {WIDTH{1'b0}};
        end
        else if (load_in)
        begin
            value_out <= data_in;
        end
    end

endmodule // ptc_cap_word

`default_nettype wire

// [bench/ptc_time_clock_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
// ****
// Port checks
// ****
module ptc_time_clock_chk (
    // Clock and reset
    input wire ref_clk_in,
    input wire rst_in,
    // Register port
    input wire [11:0] reg_addr_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [31:0] reg_wdata_in,
    input wire [31:0] reg_rdata_out,
    // Time outputs
    input wire [63:0] time_now_out,
    input wire time_match_out
);
    reg [31:0] now_lo;
    reg [31:0] t_hi;
    reg [31:0] t_lo;
    reg [31:0] m_hi;
    reg [31:0] m_lo;
    reg [1:0] t_seen;
    reg [1:0] m_seen;
    reg [63:0] tgt;
    reg prev_snap;
    wire t_up = reg_wr_in && reg_addr_in == 12'h0170;
    wire t_dn = reg_wr_in && reg_addr_in == 12'h0174;
    wire m_up = reg_wr_in && reg_addr_in == 12'h017C;
    wire m_dn = reg_wr_in && reg_addr_in == 12'h0180;
    // Halves pair in either order; the pair lands on its second half
    wire t_done = (t_seen[1] || t_up) && (t_seen[0] || t_dn);
    wire m_done = (m_seen[1] || m_up) && (m_seen[0] || m_dn);
    wire [63:0] t_val = {t_up ? reg_wdata_in : t_hi, t_dn ? reg_wdata_in : t_lo};
    wire [63:0] m_val = {m_up ? reg_wdata_in : m_hi, m_dn ? reg_wdata_in : m_lo};
    always @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            t_hi <= 32'h0000_0000;
            t_lo <= 32'h0000_0000;
            m_hi <= 32'h0000_0000;
            m_lo <= 32'h0000_0000;
            t_seen <= 2'b00;
            m_seen <= 2'b00;
            tgt <= 64'h0000_0000_0000_0000;
        end
        else
        begin
            if (t_up)
                t_hi <= reg_wdata_in;
            if (t_dn)
                t_lo <= reg_wdata_in;
            if (m_up)
                m_hi <= reg_wdata_in;
            if (m_dn)
                m_lo <= reg_wdata_in;
            if (m_done)
                tgt <= m_val;
            t_seen <= t_done ? 2'b00 : (t_seen | {t_up, t_dn});
            m_seen <= m_done ? 2'b00 : (m_seen | {m_up, m_dn});
        end
        now_lo <= time_now_out[31:0];
        prev_snap <= reg_wr_in && reg_addr_in == 12'h0198 && reg_wdata_in[0];
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    time_step_a: assert property (!reg_wr_in |=> time_now_out - $past(time_now_out) <= 64'h1)
        else $error("time counter jumped");
    time_load_a: assert property (t_done |=> time_now_out == $past(t_val))
        else $error("time load wrong");
    rd_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved");
    rd_unmap_a: assert property (reg_rd_in && reg_addr_in == 12'h0100 |=> reg_rdata_out == 32'h0)
        else $error("unmapped read not zero");
    rst_clear_a: assert property ($fell(rst_in) |-> time_now_out == 64'h0 && !time_match_out)
        else $error("reset state wrong");
    snap_read_a: assert property (prev_snap && reg_rd_in && reg_addr_in == 12'h0174
        |=> reg_rdata_out == $past(now_lo)) else $error("not snapshot");
    match_hit_a: assert property (time_now_out == tgt |=> time_match_out)
        else $error("match missed");
    match_miss_a: assert property (time_now_out != tgt |=> !time_match_out)
        else $error("false match");
endmodule // ptc_time_clock_chk
bind ptc_time_clock ptc_time_clock_chk u_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .time_now_out(time_now_out), .time_match_out(time_match_out));
`default_nettype wire

// [bench/ptc_port_model.sv]
`timescale 1ns/1ns
`default_nettype none
module ptc_port_model (
    // Clock and bench commands
    input wire logic ref_clk_in,
    input wire logic send_in,
    input wire logic [1:0] port_in,
    input wire logic sync_in,
    input wire logic [31:0] id_in,
    input wire logic [1:0] pin_req_in,
    // Toward the block
    output logic [2:0] tx_sync_seen_out = 3'h0,
    output logic [2:0] tx_delay_req_seen_out = 3'h0,
    output logic [95:0] tx_source_identity_low_out = 96'h0,
    output logic [1:0] pin_out = 2'h0
);
    always @(posedge ref_clk_in)
    begin
        tx_sync_seen_out <= 3'h0;
        tx_delay_req_seen_out <= 3'h0;
        // Identity only valid with a pulse, so scramble it otherwise
        tx_source_identity_low_out <= ~tx_source_identity_low_out;
        if (send_in)
        begin
            tx_sync_seen_out[port_in] <= sync_in;
            tx_delay_req_seen_out[port_in] <= !sync_in;
            tx_source_identity_low_out[port_in*32+:32] <= id_in;
        end
        pin_out <= pin_req_in;
    end
endmodule // ptc_port_model
`default_nettype wire

// [bench/ptp_time_clock_capture_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module ptp_time_clock_capture_tb_top;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, send = 1'b0, kind = 1'b0, tmatch;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0, sid = 32'h0, rdata, a, b;
    logic [1:0] port = 2'h0, pins = 2'h0, pin;
    logic [2:0] tsync, tdreq;
    logic [95:0] tid;
    logic [63:0] tnow, v, w;
    int err_count = 0, num_checks = 0;
    logic [11:0] offs [14] = '{12'h011C, 12'h013C, 12'h015C, 12'h0160, 12'h0164, 12'h0168,
        12'h016C, 12'h0170, 12'h0174, 12'h0178, 12'h017C, 12'h0180, 12'h0194, 12'h0100};
    logic [11:0] capofs [3] = '{12'h015C, 12'h011C, 12'h013C};
    logic [31:0] incs [3] = '{32'h8000_0000, 32'h4000_0000, 32'h0000_0000};
    always #50 clk = ~clk;
    ptc_time_clock u_dut (.ref_clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .tx_sync_seen_in(tsync),
        .tx_delay_req_seen_in(tdreq), .tx_source_identity_low_in(tid), .pin_a_in(pin[0]),
        .pin_b_in(pin[1]), .time_now_out(tnow), .time_match_out(tmatch));
    ptc_port_model u_port (.ref_clk_in(clk), .send_in(send), .port_in(port), .sync_in(kind),
        .id_in(sid), .pin_req_in(pins), .tx_sync_seen_out(tsync), .tx_delay_req_seen_out(tdreq),
        .tx_source_identity_low_out(tid), .pin_out(pin));
    function automatic logic [63:0] steps(input int n, input logic [31:0] inc);
        return (64'(n) * inc) >> 32;
    endfunction
    function automatic logic [31:0] cap_exp(input int m, input logic [31:0] s, input logic [31:0] d);
        return m ? s : d;
    endfunction
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [11:0] ad, input logic [31:0] d);
        @(negedge clk);
        {wr, rd, addr, wdata} = {2'b10, ad, d};
    endtask
    task automatic rd_reg(input logic [11:0] ad, input logic [31:0] exp);
        @(negedge clk);
        {wr, rd, addr} = {2'b01, ad};
        @(negedge clk);
        rd = 1'b0;
        chk("rdata", {32'h0, exp}, {32'h0, rdata});
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk) {wr, rd} = 2'b00;
    endtask
    task automatic pair(input logic [11:0] ad, input logic [63:0] val);
        wr_reg(ad, val[63:32]);
        wr_reg(ad + 12'h4, val[31:0]);
        idle(1);
    endtask
    task automatic emit(input int p, input logic s, input logic [31:0] id);
        @(negedge clk);
        {wr, rd, send, port, kind, sid} = {3'b001, 2'(p), s, id};
        @(negedge clk) send = 1'b0;
    endtask
    task automatic finish_test;
        if (err_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #(100 * 3000);
        err_count++;
        finish_test();
    end
    initial
    begin
        void'($urandom(32'h40e9));
        repeat (8) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        foreach (offs[i]) rd_reg(offs[i], 32'h0);
        v = {$urandom, $urandom};
        pair(12'h0170, v);
        chk("time", v, tnow);
        wr_reg(12'h0170, ~v[63:32]);
        idle(2);
        chk("half time", v, tnow);
        w = {~v[63:32], $urandom};
        pair(12'h0170, w);
        wr_reg(12'h0198, 32'h1);
        rd_reg(12'h0174, w[31:0]);
        rd_reg(12'h0170, w[63:32]);
        pair(12'h0170, v);
        rd_reg(12'h0174, w[31:0]);
        foreach (incs[i])
        begin
            wr_reg(12'h0178, incs[i]);
            rd_reg(12'h0178, incs[i]);
            pair(12'h0170, v);
            idle(20);
            chk("rate", v + steps(20, incs[i]), tnow);
        end
        pair(12'h017C, v);
        idle(2);
        chk("match", 64'h1, {63'h0, tmatch});
        rd_reg(12'h0180, v[31:0]);
        wr_reg(12'h017C, ~v[63:32]);
        idle(2);
        chk("match half", 64'h1, {63'h0, tmatch});
        pair(12'h017C, {~v[63:32], v[31:0]});
        idle(2);
        chk("match off", 64'h0, {63'h0, tmatch});
        for (int p = 0; p < 3; p++)
            for (int m = 0; m < 2; m++)
            begin
                a = $urandom;
                b = $urandom;
                wr_reg(12'h0194, 32'(m) << (29 + p));
                emit(p, 1'b1, a);
                emit(p, 1'b0, b);
                rd_reg(capofs[p], cap_exp(m, a, b));
                wr_reg(capofs[p], ~a);
                rd_reg(capofs[p], cap_exp(m, a, b));
            end
        @(negedge clk) pins = 2'b01;
        idle(6);
        rd_reg(12'h0160, v[63:32]);
        rd_reg(12'h0164, v[31:0]);
        pair(12'h0170, w);
        @(negedge clk) pins = 2'b11;
        idle(6);
        rd_reg(12'h0168, w[63:32]);
        rd_reg(12'h016C, w[31:0]);
        rd_reg(12'h0164, v[31:0]);
        finish_test();
    end
endmodule // ptp_time_clock_capture_tb_top
`default_nettype wire
